// >>> rtl/ipvs_consts.svh
/*
 offsets, field masks, reset values and status bit positions of the
 interrupt priority and vector status block. assumes nothing.
*/
`ifndef IPVS_CONSTS_SVH
`define IPVS_CONSTS_SVH

`define IPVS_ADDR_W 4
`define IPVS_NUM_PRIO 7
`define IPVS_NUM_SRC 14
`define IPVS_A_STAT 4'h7
`define IPVS_A_EVT 4'h8
`define IPVS_A_EMASK 4'h9

`define IPVS_M0 16'h7777
`define IPVS_M1 16'h0007
`define IPVS_M2 16'h7770
`define IPVS_M3 16'h0700
`define IPVS_M4 16'h7770
`define IPVS_M5 16'h0007
`define IPVS_M6 16'h0070

`define IPVS_R0 16'h4444
`define IPVS_R1 16'h0004
`define IPVS_R2 16'h4440
`define IPVS_R3 16'h0400
`define IPVS_R4 16'h4440
`define IPVS_R5 16'h0004
`define IPVS_R6 16'h0040

`define IPVS_LVL_OFF 3'h0
`define IPVS_ST_REQ 15
`define IPVS_ST_HOLD 13
`define IPVS_EVT_W 3
`define IPVS_EV_RAISE 0
`define IPVS_EV_ACK 1
`define IPVS_EV_BLOCK 2

`endif

// >>> rtl/ipvs_pkg.sv
/*
 types of the interrupt priority and vector status block.
 assumes the constants header is compiled alongside.
*/
`default_nettype none

package ipvs_pkg;
	typedef logic [2:0] ipvs_level_t;
	typedef logic [3:0] ipvs_cpu_level_t;
	typedef logic [6:0] ipvs_vec_t;
	typedef enum logic [0:0]
	{
		IPVS_IDLE = 1'b0,
		IPVS_OFFER = 1'b1
	} ipvs_state_t;
endpackage : ipvs_pkg

`default_nettype wire

// >>> rtl/ipvs_ctrl.sv
/*
 interrupt priority registers, source arbitration and the control and
 status register. assumes sources, core and register master all run on
 clock; source enables and flags are handled before src_pend.
*/
// Summary of operation
// - 3-bit field is the level, 7 highest, 1 lowest, 0 disables source.
// - reset sets every priority field to level 4.
// - unimplemented bits ignore writes and read as zero.
// - first register: change 14-12, comparator 10-8, master 6-4, slave 2-0.
// - external one register holds only bits 2-0.
// - serial two tx 14-12, rx 10-8, external two 6-4, bits 3-0 unused.
// - checksum 14-12, serial two error 10-8, serial one error 6-4.
// - voltage detect level in bits 2-0, rest unimplemented.
// - charge measure level in bits 6-4, bits 15-7 zero.
// - status bit 15 set while a pending request is held off by cpu level.
// - status bit 13 picks highest pending vector or last acknowledged one.
// - status bits 11-8 show the new cpu level, 0 to 7.
// - status bits 6-0 show the vector code.
// - cpu level 7 or above masks every user source.
`timescale 1ns/1ps
`default_nettype none
`include "ipvs_consts.svh"

module ipvs_ctrl
(
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic [13:0] src_pend,
	input wire logic [3:0] cpu_level,
	input wire logic cpu_ack,
	output logic cpu_irq,
	output ipvs_pkg::ipvs_vec_t cpu_vec,
	output ipvs_pkg::ipvs_level_t cpu_irq_level,
	output logic irq
);

	// ----------------------------------------
	// register layout helpers
	// ----------------------------------------
	function automatic logic [15:0] mask_of(input logic [2:0] i);
		case (i)
			3'h0: mask_of = `IPVS_M0;
			3'h1: mask_of = `IPVS_M1;
			3'h2: mask_of = `IPVS_M2;
			3'h3: mask_of = `IPVS_M3;
			3'h4: mask_of = `IPVS_M4;
			3'h5: mask_of = `IPVS_M5;
			3'h6: mask_of = `IPVS_M6;
			default: mask_of = 16'h0000;
		endcase
	endfunction : mask_of

	function automatic logic [15:0] rst_of(input logic [2:0] i);
		case (i)
			3'h0: rst_of = `IPVS_R0;
			3'h1: rst_of = `IPVS_R1;
			3'h2: rst_of = `IPVS_R2;
			3'h3: rst_of = `IPVS_R3;
			3'h4: rst_of = `IPVS_R4;
			3'h5: rst_of = `IPVS_R5;
			3'h6: rst_of = `IPVS_R6;
			default: rst_of = 16'h0000;
		endcase
	endfunction : rst_of

	// ----------------------------------------
	// priority registers
	// ----------------------------------------
	logic [15:0] prio [0:6];

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < `IPVS_NUM_PRIO; i++)
		begin
			if (srst)
				prio[i] <= rst_of(3'(i));
			else if (ce && wr && addr == 4'(i))
				prio[i] <= wdata & mask_of(3'(i));
		end
	end

	ipvs_pkg::ipvs_level_t src_lvl [0:13];

	assign src_lvl[0] = prio[0][14:12];
	assign src_lvl[1] = prio[0][10:8];
	assign src_lvl[2] = prio[0][6:4];
	assign src_lvl[3] = prio[0][2:0];
	assign src_lvl[4] = prio[1][2:0];
	assign src_lvl[5] = prio[2][14:12];
	assign src_lvl[6] = prio[2][10:8];
	assign src_lvl[7] = prio[2][6:4];
	assign src_lvl[8] = prio[3][10:8];
	assign src_lvl[9] = prio[4][14:12];
	assign src_lvl[10] = prio[4][10:8];
	assign src_lvl[11] = prio[4][6:4];
	assign src_lvl[12] = prio[5][2:0];
	assign src_lvl[13] = prio[6][6:4];

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	logic any_pend;
	ipvs_pkg::ipvs_level_t best_lvl;
	ipvs_pkg::ipvs_vec_t best_vec;
	logic beats;
	logic held_off;

	// ascending scan with strict compare keeps the lowest code on a tie
	always_comb
	begin
		any_pend = 1'b0;
		best_lvl = `IPVS_LVL_OFF;
		best_vec = 7'h00;
		for (int i = 0; i < `IPVS_NUM_SRC; i++)
		begin
			if (src_pend[i] && src_lvl[i] != `IPVS_LVL_OFF && src_lvl[i] > best_lvl)
			begin
				any_pend = 1'b1;
				best_lvl = src_lvl[i];
				best_vec = 7'(i);
			end
		end
	end

	// user levels stop at 7, so cpu level 7 and traps above hold everything off
	assign beats = any_pend && {1'b0, best_lvl} > cpu_level;
	assign held_off = any_pend && !beats;

	// ----------------------------------------
	// request to the core
	// ----------------------------------------
	ipvs_pkg::ipvs_state_t state;
	ipvs_pkg::ipvs_state_t next_state;
	logic vec_hold;
	ipvs_pkg::ipvs_vec_t last_vec;
	ipvs_pkg::ipvs_cpu_level_t new_lvl;

	always_comb
	begin
		case (state)
			ipvs_pkg::IPVS_IDLE: next_state = beats ? ipvs_pkg::IPVS_OFFER : ipvs_pkg::IPVS_IDLE;
			ipvs_pkg::IPVS_OFFER:
			begin
				if (cpu_ack || !beats)
					next_state = ipvs_pkg::IPVS_IDLE;
				else
					next_state = ipvs_pkg::IPVS_OFFER;
			end
			default: next_state = ipvs_pkg::IPVS_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			state <= ipvs_pkg::IPVS_IDLE;
		else if (ce)
			state <= next_state;
	end

	// a higher source arriving during an offer replaces the offered vector
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			cpu_vec <= 7'h00;
			cpu_irq_level <= 3'h0;
		end
		else if (ce && beats && !(state == ipvs_pkg::IPVS_OFFER && cpu_ack))
		begin
			cpu_vec <= best_vec;
			cpu_irq_level <= best_lvl;
		end
	end

	assign cpu_irq = state == ipvs_pkg::IPVS_OFFER;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			last_vec <= 7'h00;
			new_lvl <= 4'h0;
		end
		else if (ce && cpu_irq && cpu_ack)
		begin
			last_vec <= cpu_vec;
			new_lvl <= {1'b0, cpu_irq_level};
		end
	end

	// ----------------------------------------
	// control and status register
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
			vec_hold <= 1'b0;
		else if (ce && wr && addr == `IPVS_A_STAT)
			vec_hold <= wdata[`IPVS_ST_HOLD];
	end

	logic [15:0] stat_word;
	ipvs_pkg::ipvs_vec_t shown_vec;

	assign shown_vec = vec_hold ? best_vec : last_vec;
	assign stat_word = {held_off, 1'b0, vec_hold, 1'b0, new_lvl, 1'b0, shown_vec};

	// ----------------------------------------
	// event flags and interrupt
	// ----------------------------------------
	logic [2:0] evt;
	logic [2:0] evt_mask;
	logic [2:0] evt_set;
	logic held_d;

	always_ff @(posedge clock)
	begin
		if (srst)
			held_d <= 1'b0;
		else if (ce)
			held_d <= held_off;
	end

	assign evt_set[`IPVS_EV_RAISE] = ce && state == ipvs_pkg::IPVS_IDLE && beats;
	assign evt_set[`IPVS_EV_ACK] = ce && cpu_irq && cpu_ack;
	assign evt_set[`IPVS_EV_BLOCK] = ce && held_off && !held_d;

	// a new event beats a write-one clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (srst)
			evt <= 3'h0;
		else if (ce)
			evt <= (evt & ~((wr && addr == `IPVS_A_EVT) ? wdata[2:0] : 3'h0)) | evt_set;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			evt_mask <= 3'h0;
		else if (ce && wr && addr == `IPVS_A_EMASK)
			evt_mask <= wdata[2:0];
	end

	assign irq = |(evt & evt_mask);

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
			rdata <= 16'h0000;
		else if (ce)
		begin
			if (!rd)
				rdata <= 16'h0000;
			else if (addr < 4'h7)
				rdata <= prio[addr[2:0]];
			else if (addr == `IPVS_A_STAT)
				rdata <= stat_word;
			else if (addr == `IPVS_A_EVT)
				rdata <= {13'h0000, evt};
			else if (addr == `IPVS_A_EMASK)
				rdata <= {13'h0000, evt_mask};
			else
				rdata <= 16'h0000;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	property p_disabled_silent;
		(ce && !any_pend) |=> !cpu_irq;
	endproperty
	a_disabled_silent: assert property (p_disabled_silent) else $error("request without enabled source");

	property p_reset_levels;
		$fell(srst) |-> prio[0] == `IPVS_R0 && prio[2] == `IPVS_R2 && prio[6] == `IPVS_R6;
	endproperty
	a_reset_levels: assert property (p_reset_levels) else $error("priority reset value wrong");

	property p_stat_zero_bits;
		(ce && rd && addr == `IPVS_A_STAT) |=> rdata[14] == 1'b0 && rdata[12] == 1'b0 && rdata[7] == 1'b0;
	endproperty
	a_stat_zero_bits: assert property (p_stat_zero_bits) else $error("unimplemented status bit set");

	property p_first_layout;
		(ce && wr && addr == 4'h0) |=> src_lvl[0] == $past(wdata[14:12]) && src_lvl[3] == $past(wdata[2:0]);
	endproperty
	a_first_layout: assert property (p_first_layout) else $error("first register field misplaced");

	property p_charge_layout;
		(ce && wr && addr == 4'h6) |=> prio[6] == ($past(wdata) & 16'h0070);
	endproperty
	a_charge_layout: assert property (p_charge_layout) else $error("charge register bits wrong");

	property p_held_bit;
		(ce && rd && addr == `IPVS_A_STAT) |=> rdata[15] == $past(held_off);
	endproperty
	a_held_bit: assert property (p_held_bit) else $error("held-off bit wrong");

	property p_hold_select;
		(ce && rd && addr == `IPVS_A_STAT && vec_hold) |=> rdata[6:0] == $past(best_vec);
	endproperty
	a_hold_select: assert property (p_hold_select) else $error("vector field not highest pending");

	property p_ack_level;
		(ce && cpu_irq && cpu_ack) |=> new_lvl == {1'b0, $past(cpu_irq_level)} && last_vec == $past(cpu_vec);
	endproperty
	a_ack_level: assert property (p_ack_level) else $error("acknowledge not captured");

	property p_cpu_seven;
		(ce && state == ipvs_pkg::IPVS_IDLE && cpu_level >= 4'h7) |=> !cpu_irq;
	endproperty
	a_cpu_seven: assert property (p_cpu_seven) else $error("request through cpu level 7");

	property p_offer;
		(ce && state == ipvs_pkg::IPVS_IDLE && beats) |=> cpu_irq && cpu_vec == $past(best_vec);
	endproperty
	a_offer: assert property (p_offer) else $error("winning source not offered");

	c_offer_ack: cover property (cpu_irq && cpu_ack);
	c_held: cover property (held_off ##1 held_off);
	c_withdraw: cover property (cpu_irq ##1 !cpu_irq && !$past(cpu_ack));

endmodule : ipvs_ctrl

`default_nettype wire

// >>> tb/ipvs_core_model.sv
/*
 core model: takes an offered request after a chosen delay.
 assumes the block's clock and synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none

module ipvs_core_model
(
	input wire logic clock,
	input wire logic srst,
	input wire logic en,
	input wire logic [1:0] delay,
	input wire logic cpu_irq,
	output logic cpu_ack
);
	logic [1:0] cnt;

	// ack only while the offer stands, one cycle long, so a withdrawn offer is never taken
	always_ff @(posedge clock)
	begin
		if (srst || !en || !cpu_irq || cpu_ack)
		begin
			cnt <= 2'h0;
			cpu_ack <= 1'b0;
		end
		else if (cnt == delay)
			cpu_ack <= 1'b1;
		else
			cnt <= cnt + 2'h1;
	end
endmodule : ipvs_core_model

`default_nettype wire

// >>> tb/test_interrupt_priority_and_vector_status.sv
/*
 self-checking bench of the priority and vector status block.
 assumes the constants header and package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ipvs_consts.svh"

module test_interrupt_priority_and_vector_status;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic en = 1'b0;
	logic ce = 1'b1;
	logic [1:0] dly = 2'h0;
	logic [3:0] addr = 4'h0;
	logic [3:0] cpu_level = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [13:0] src_pend = 14'h0000;
	logic [15:0] rdata;
	logic cpu_ack;
	logic cpu_irq;
	logic irq;
	ipvs_pkg::ipvs_vec_t cpu_vec;
	ipvs_pkg::ipvs_level_t cpu_irq_level;
	logic [15:0] msk [7] = '{`IPVS_M0, `IPVS_M1, `IPVS_M2, `IPVS_M3, `IPVS_M4, `IPVS_M5, `IPVS_M6};
	logic [15:0] rst_v [7] = '{`IPVS_R0, `IPVS_R1, `IPVS_R2, `IPVS_R3, `IPVS_R4, `IPVS_R5, `IPVS_R6};
	int rg [14] = '{0, 0, 0, 0, 1, 2, 2, 2, 3, 4, 4, 4, 5, 6};
	int lsb [14] = '{12, 8, 4, 0, 0, 12, 8, 4, 8, 12, 8, 4, 0, 4};
	logic [15:0] sh [7];
	int seed = 26;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	ipvs_ctrl i_dut (.clock(clock), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .src_pend(src_pend), .cpu_level(cpu_level), .cpu_ack(cpu_ack), .cpu_irq(cpu_irq),
		.cpu_vec(cpu_vec), .cpu_irq_level(cpu_irq_level), .irq(irq));

	ipvs_core_model i_core (.clock(clock), .srst(srst), .en(en), .delay(dly), .cpu_irq(cpu_irq),
		.cpu_ack(cpu_ack));

	always #2 clock = ~clock;

	// ----------------------------------------
	// checks and bus cycles
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_chk

	function automatic int lvl(input int i);
		return (sh[rg[i]] >> lsb[i]) & 7;
	endfunction : lvl

	// a hang costs one mismatch and ends the run
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		int i, w, hp, win, held, evt, last_lvl, last_vec;
		last_lvl = 0;
		last_vec = 0;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		for (i = 0; i < 7; i++)
			rd_chk(i[3:0], rst_v[i]);
		for (i = 0; i < 11; i++)
		begin
			w = $random(seed);
			wr_reg(i[3:0], w[15:0]);
			if (i < 7)
				rd_chk(i[3:0], w[15:0] & msk[i]);
		end
		rd_chk(4'hA, 16'h0000);
		// clock enable low must freeze the registers
		wr_reg(4'h0, 16'h1234);
		@(posedge clock);
		ce <= 1'b0;
		wr_reg(4'h0, 16'h7777);
		@(posedge clock);
		ce <= 1'b1;
		rd_chk(4'h0, 16'h1234);
		for (int n = 0; n < 60; n++)
		begin
			for (i = 0; i < 7; i++)
			begin
				w = $random(seed);
				sh[i] = w[15:0] & msk[i];
				wr_reg(i[3:0], w[15:0]);
			end
			wr_reg(4'h8, 16'h0007);
			wr_reg(4'h7, 16'hFFFF);
			w = $random(seed);
			@(posedge clock);
			src_pend <= w[13:0];
			cpu_level <= w[19:16];
			dly <= w[21:20];
			hp = -1;
			for (i = 0; i < 14; i++)
				if (w[i] && lvl(i) != 0 && (hp < 0 || lvl(i) > lvl(hp)))
					hp = i;
			win = (hp >= 0 && lvl(hp) > w[19:16]) ? hp : -1;
			held = (hp >= 0 && win < 0);
			repeat (3) @(posedge clock);
			#1;
			if (win >= 0)
				chk({cpu_irq, cpu_irq_level, 5'h00, cpu_vec}, {1'b1, 3'(lvl(win)), 5'h00, win[6:0]});
			else
				chk({15'h0000, cpu_irq}, 16'h0000);
			rd_chk(4'h7, {held[0], 2'b01, 1'b0, last_lvl[3:0], 1'b0, (hp >= 0) ? hp[6:0] : 7'h00});
			@(posedge clock);
			en <= (win >= 0);
			i = 0;
			if (win >= 0)
			begin
				do
					@(posedge clock);
				while (cpu_ack !== 1'b1 && ++i < 30);
				last_lvl = lvl(win);
				last_vec = win;
			end
			en <= 1'b0;
			src_pend <= 14'h0000;
			repeat (2) @(posedge clock);
			wr_reg(4'h7, 16'h0000);
			rd_chk(4'h7, {4'h0, last_lvl[3:0], 1'b0, last_vec[6:0]});
			evt = (win >= 0) ? 3 : (held ? 4 : 0);
			rd_chk(4'h8, evt[15:0]);
			w = $random(seed);
			wr_reg(4'h9, w[15:0]);
			chk({15'h0000, irq}, {15'h0000, |(evt[2:0] & w[2:0])});
		end
		report_and_stop();
	end
endmodule : test_interrupt_priority_and_vector_status

`default_nettype wire
